/* tmc_timer.sv */
// Purpose: two 8/13/16-bit timer/counters with Avalon-MM registers
// Assumes: i_clk is the 250 MHz CPU clock, pins synchronous to it
// Notes:   one wait state on every bus access
// Notes on behaviour
// - timer function adds one every machine cycle of six clocks
// - counter function samples pin per machine cycle, counts high-then-low
// - count appears one machine cycle after the edge was detected
// - each timer has own counter select bit and two-bit mode field
// - mode 0 counts 13 bits: high byte plus low five bits
// - overflow flag sets when count wraps from all ones, to zero or to the mode 2 reload value
// - count only when run set and gate clear or gate input high
// - setting run bit leaves the count bytes untouched
// - gate bit is mode bit 7 for timer 1, bit 3 for timer 0
// - mode 1 counts the full sixteen bits
// - mode 2 counts low byte, reloads it from high byte on overflow
// - timer 1 in mode 3 is halted like run bit clear
// - timer 0 mode 3: low byte own counter, high byte uses timer 1 run and flag
// - then timer 1 runs outside mode 3, stops in it, no interrupt flag
// - toggle enable inverts the timer's pin output on each overflow
// - pin output reads one after enabling until first overflow
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_cfg.svh"
module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_count_pin_zero,
  input  wire logic        i_count_pin_one,
  output logic             o_count_pin_zero,
  output logic             o_count_pin_zero_oe_n,
  output logic             o_count_pin_one,
  output logic             o_count_pin_one_oe_n,
  input  wire logic        i_ext_gate_input_zero,
  input  wire logic        i_ext_gate_input_one,
  input  wire logic [1:0]  i_flag_ack,
  output logic             o_irq,
  output logic             o_baud_tick
);

  tmc_tick_if tif ();

  tmc_tick u_tick (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .tif     (tif)
  );

  assign tif.pin = {i_count_pin_one, i_count_pin_zero};

  logic [7:0] timer_mode_register;
  logic [1:0] run_control;
  logic [1:0] overflow_flag;
  logic [1:0] toggle_en;
  logic [1:0] toggle_lvl;
  logic [1:0] pin_oe_n;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] ovf;
  logic [1:0] set_flag;
  logic       split;
  logic       hi_ovf;
  logic       bus_req;
  logic       bus_go;
  logic       wr;
  logic [7:0] wdata;

  assign bus_req = i_avs_read | i_avs_write;
  assign bus_go  = bus_req & ~o_avs_waitrequest;
  assign wr      = bus_go & i_avs_write & i_avs_byteenable[0];
  assign wdata   = i_avs_writedata[7:0];

  // one wait state: request seen, then released at the next edge
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
    end
  end

  assign split = (tmc_mode_t'(timer_mode_register[1:0]) == TMC_SPLIT);

  for (genvar i = 0; i < 2; i++) begin : g_tm
    localparam int SH = `TMC_MODE_LSB + i * `TMC_T1_SHIFT;
    localparam logic [7:0] A_LO = (i == 0) ? `TMC_OFF_LO0 : `TMC_OFF_LO1;
    localparam logic [7:0] A_HI = (i == 0) ? `TMC_OFF_HI0 : `TMC_OFF_HI1;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  next_lo;
    logic [7:0]  next_hi;
    logic [12:0] c13;
    logic [15:0] c16;
    tmc_mode_t   md;
    logic        ct;
    logic        gate;
    logic        gin;
    logic        run;
    logic        inc;
    logic        wr_lo;
    logic        wr_hi;

    assign md   = tmc_mode_t'(timer_mode_register[SH +: 2]);
    assign ct   = timer_mode_register[SH + `TMC_CT_BIT];
    assign gate = timer_mode_register[SH + `TMC_GATE_BIT];
    assign gin  = (i == 0) ? i_ext_gate_input_zero : i_ext_gate_input_one;
    if (i == 0) begin : g_run0
      assign run = run_control[0];
    end else begin : g_run1
      // under split the run bit belongs to the high byte of timer 0
      assign run = (split | run_control[1]) & (md != TMC_SPLIT);
    end
    assign inc   = run & (~gate | gin) & tif.tick & (~ct | tif.fall[i]);
    assign c13   = {hi, lo[4:0]};
    assign c16   = {hi, lo};
    assign wr_lo = wr & (i_avs_address == A_LO);
    assign wr_hi = wr & (i_avs_address == A_HI);

    always_comb begin
      next_lo = lo;
      next_hi = hi;
      ovf[i]  = 1'b0;
      if (inc) begin
        case (md)
          TMC_M13: begin
            {next_hi, next_lo[4:0]} = c13 + 13'h1;
            ovf[i] = (c13 == 13'h1FFF);
          end
          TMC_M16: begin
            {next_hi, next_lo} = c16 + 16'h1;
            ovf[i] = (c16 == 16'hFFFF);
          end
          TMC_M8R: begin
            next_lo = (lo == 8'hFF) ? hi : lo + 8'h1;
            ovf[i] = (lo == 8'hFF);
          end
          TMC_SPLIT: begin
            next_lo = lo + 8'h1;
            ovf[i] = (lo == 8'hFF);
          end
          default: begin
            next_lo = lo;
          end
        endcase
      end
      if (i == 0 && split && tif.tick && run_control[1]) begin
        next_hi = hi + 8'h1;
      end
    end

    // a write wins over counting in the same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        lo <= `TMC_RST_BYTE;
        hi <= `TMC_RST_BYTE;
      end else begin
        lo <= wr_lo ? wdata : next_lo;
        hi <= wr_hi ? wdata : next_hi;
      end
    end
  end

  assign hi_ovf   = split & tif.tick & run_control[1] & (g_tm[0].hi == 8'hFF);
  // timer 1 loses its flag while timer 0 is split
  assign set_flag = {split ? hi_ovf : ovf[1], ovf[0]};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      timer_mode_register <= `TMC_RST_BYTE;
    end else if (wr && i_avs_address == `TMC_OFF_MODE) begin
      timer_mode_register <= wdata;
    end
  end

  // run bits only gate counting, the bytes are not cleared
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      run_control   <= `TMC_RST_PAIR;
      overflow_flag <= `TMC_RST_PAIR;
    end else if (wr && i_avs_address == `TMC_OFF_CTRL) begin
      run_control   <= {wdata[`TMC_TR1_BIT], wdata[`TMC_TR0_BIT]};
      overflow_flag <= {wdata[`TMC_TF1_BIT], wdata[`TMC_TF0_BIT]} | set_flag;
    end else begin
      overflow_flag <= (overflow_flag & ~i_flag_ack) | set_flag;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      toggle_en  <= `TMC_RST_PAIR;
      toggle_lvl <= `TMC_RST_TOG;
      pin_oe_n   <= `TMC_RST_TOG;
    end else begin
      if (wr && i_avs_address == `TMC_OFF_PORT) begin
        toggle_en <= {wdata[`TMC_TOG1_BIT], wdata[`TMC_TOG0_BIT]};
        // kept as its own flop so the enable pins leave straight from a register
        pin_oe_n  <= ~{wdata[`TMC_TOG1_BIT], wdata[`TMC_TOG0_BIT]};
      end
      for (int k = 0; k < 2; k++) begin
        if (wr && i_avs_address == `TMC_OFF_PORT && wdata[k] && !toggle_en[k]) begin
          toggle_lvl[k] <= 1'b1;
        end else if (toggle_en[k] && ovf[k]) begin
          toggle_lvl[k] <= ~toggle_lvl[k];
        end
      end
    end
  end

  assign o_count_pin_zero      = toggle_lvl[0];
  assign o_count_pin_one       = toggle_lvl[1];
  assign o_count_pin_zero_oe_n = pin_oe_n[0];
  assign o_count_pin_one_oe_n  = pin_oe_n[1];

  // set wins over the write-one clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat <= `TMC_RST_PAIR;
      irq_mask <= `TMC_RST_PAIR;
      o_irq    <= 1'b0;
    end else begin
      if (wr && i_avs_address == `TMC_OFF_ISTAT) begin
        irq_stat <= (irq_stat & ~wdata[1:0]) | set_flag;
      end else begin
        irq_stat <= irq_stat | set_flag;
      end
      if (wr && i_avs_address == `TMC_OFF_IMASK) begin
        irq_mask <= wdata[1:0];
      end
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_baud_tick <= 1'b0;
    end else begin
      o_baud_tick <= ovf[1];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0;
    end else if (bus_req && o_avs_waitrequest && i_avs_read) begin
      case (i_avs_address)
        `TMC_OFF_MODE:  o_avs_readdata <= {24'h0, timer_mode_register};
        `TMC_OFF_CTRL:  o_avs_readdata <= {24'h0, overflow_flag[1], run_control[1],
                                           overflow_flag[0], run_control[0], 4'h0};
        `TMC_OFF_LO0:   o_avs_readdata <= {24'h0, g_tm[0].lo};
        `TMC_OFF_HI0:   o_avs_readdata <= {24'h0, g_tm[0].hi};
        `TMC_OFF_LO1:   o_avs_readdata <= {24'h0, g_tm[1].lo};
        `TMC_OFF_HI1:   o_avs_readdata <= {24'h0, g_tm[1].hi};
        `TMC_OFF_PORT:  o_avs_readdata <= {30'h0, toggle_en};
        `TMC_OFF_ISTAT: o_avs_readdata <= {30'h0, irq_stat};
        `TMC_OFF_IMASK: o_avs_readdata <= {30'h0, irq_mask};
        default:        o_avs_readdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  logic quiet0;
  logic quiet1;
  assign quiet0 = ~(g_tm[0].wr_lo | g_tm[0].wr_hi);
  assign quiet1 = ~(g_tm[1].wr_lo | g_tm[1].wr_hi);

  a_tick_period: assert property (
    tif.tick |=> !tif.tick [*5] ##1 tif.tick)
    else $error("machine cycle is not six clocks");

  a_timer_step: assert property (
    tif.tick && g_tm[0].run && !g_tm[0].ct && !g_tm[0].gate && g_tm[0].md == TMC_M16 && quiet0
    |=> {g_tm[0].hi, g_tm[0].lo} == 16'($past({g_tm[0].hi, g_tm[0].lo}) + 16'h1))
    else $error("timer did not step by one");

  a_no_edge_hold: assert property (
    g_tm[0].ct && !tif.fall[0] && quiet0 && !split |=> $stable({g_tm[0].hi, g_tm[0].lo}))
    else $error("counter moved without a pin edge");

  a_mode0_carry: assert property (
    g_tm[0].inc && g_tm[0].md == TMC_M13 && g_tm[0].lo[4:0] == 5'h1F && quiet0
    |=> g_tm[0].lo[4:0] == 5'h00 && g_tm[0].hi == 8'($past(g_tm[0].hi) + 8'h1))
    else $error("13-bit carry wrong");

  a_flag_set: assert property (
    ovf[0] ##1 !i_flag_ack[0] [*2] |-> overflow_flag[0])
    else $error("overflow flag not set");

  a_flag_ack_clear: assert property (
    i_flag_ack[0] && !set_flag[0] && !(wr && i_avs_address == `TMC_OFF_CTRL)
    |=> !overflow_flag[0])
    else $error("serviced flag did not clear");

  a_split_no_flag: assert property (
    split && !hi_ovf && !overflow_flag[1] && !(wr && i_avs_address == `TMC_OFF_CTRL)
    |=> !overflow_flag[1])
    else $error("timer 1 set its flag while timer 0 split");

  a_gate_stop: assert property (
    g_tm[0].gate && !i_ext_gate_input_zero && quiet0 && !split
    |=> $stable({g_tm[0].hi, g_tm[0].lo}))
    else $error("gated timer counted");

  a_reload_low: assert property (
    g_tm[1].md == TMC_M8R && ovf[1] && quiet1
    |=> g_tm[1].lo == $past(g_tm[1].hi) && $stable(g_tm[1].hi))
    else $error("auto reload wrong");

  a_t1_halted: assert property (
    g_tm[1].md == TMC_SPLIT && quiet1 |=> $stable({g_tm[1].hi, g_tm[1].lo}))
    else $error("timer 1 ran in mode 3");

  a_split_flag: assert property (
    hi_ovf |=> overflow_flag[1] && g_tm[0].hi == 8'h00)
    else $error("split high byte overflow lost");

  a_pin_toggle: assert property (
    toggle_en[0] && ovf[0] && !(wr && i_avs_address == `TMC_OFF_PORT)
    |=> o_count_pin_zero != $past(o_count_pin_zero))
    else $error("pin did not toggle");

  a_pin_start: assert property (
    wr && i_avs_address == `TMC_OFF_PORT && wdata[0] && !toggle_en[0]
    |=> o_count_pin_zero && !o_count_pin_zero_oe_n)
    else $error("toggle pin not high after enable");

  a_baud_pulse: assert property (
    ovf[1] |=> o_baud_tick ##1 (!o_baud_tick || $past(ovf[1])))
    else $error("baud pulse missing");

  c_split_ovf: cover property (split && hi_ovf);
  c_count_edge: cover property (g_tm[0].ct && tif.fall[0] && g_tm[0].inc);
  c_toggle: cover property (toggle_en[1] && ovf[1]);
  c_irq: cover property (o_irq);

endmodule
`default_nettype wire

/* tmc_cfg.svh */
// Purpose: offsets, field positions, reset values and counts for the timer block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per word
// Notes:   register contents are at most 8 bits wide in the low byte lane
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

`define TMC_OFF_MODE     8'h00
`define TMC_OFF_CTRL     8'h04
`define TMC_OFF_LO0      8'h08
`define TMC_OFF_HI0      8'h0C
`define TMC_OFF_LO1      8'h10
`define TMC_OFF_HI1      8'h14
`define TMC_OFF_PORT     8'h18
`define TMC_OFF_ISTAT    8'h1C
`define TMC_OFF_IMASK    8'h20

`define TMC_MODE_LSB     0
`define TMC_CT_BIT       2
`define TMC_GATE_BIT     3
`define TMC_T1_SHIFT     4

`define TMC_TR0_BIT      4
`define TMC_TF0_BIT      5
`define TMC_TR1_BIT      6
`define TMC_TF1_BIT      7

`define TMC_TOG0_BIT     0
`define TMC_TOG1_BIT     1

`define TMC_RST_BYTE     8'h00
`define TMC_RST_PAIR     2'h0
`define TMC_RST_TOG      2'h3

`define TMC_MC_LAST      3'h5

`endif

/* tmc_pkg.sv */
// Purpose: shared types of the timer block
// Assumes: tmc_cfg.svh holds the numbers
// Notes:   mode codes follow the two-bit mode field
package tmc_pkg;

  typedef enum logic [1:0] {
    TMC_M13   = 2'h0,
    TMC_M16   = 2'h1,
    TMC_M8R   = 2'h2,
    TMC_SPLIT = 2'h3
  } tmc_mode_t;

endpackage

/* tmc_tick_if.sv */
// Purpose: machine-cycle tick and pin edge events between prescaler and timers
// Assumes: one clock domain
// Notes:   fall bits are only ever high together with tick
`timescale 1ns/1ns
`default_nettype none
interface tmc_tick_if;
  logic       tick;
  logic [1:0] pin;
  logic [1:0] fall;

  modport gen (input pin, output tick, output fall);
  modport use_side (output pin, input tick, input fall);
endinterface
`default_nettype wire

/* tmc_tick.sv */
// Purpose: machine-cycle prescaler and count-pin falling edge detection
// Assumes: pins synchronous to i_clk
// Notes:   edge seen in one machine cycle is reported at the next tick
`timescale 1ns/1ns
`default_nettype none
`include "tmc_cfg.svh"
module tmc_tick
  import tmc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  tmc_tick_if.gen   tif
);

  logic [2:0] mc_cnt;
  logic [1:0] smp;
  logic [1:0] prv;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mc_cnt <= 3'h0;
    end else if (mc_cnt == `TMC_MC_LAST) begin
      mc_cnt <= 3'h0;
    end else begin
      mc_cnt <= mc_cnt + 3'h1;
    end
  end

  assign tif.tick = (mc_cnt == `TMC_MC_LAST);

  // one sample per machine cycle, so edges shorter than that may be missed
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      smp <= 2'h0;
      prv <= 2'h0;
    end else if (tif.tick) begin
      smp <= tif.pin;
      prv <= smp;
    end
  end

  // reported one tick after the low sample: two machine cycles per edge
  assign tif.fall = {2{tif.tick}} & prv & ~smp;

endmodule
`default_nettype wire

/* tmc_pin_src.sv */
// Purpose: far-side source for the count pins and the external gate inputs
// Assumes: i_half below six parks both count pins high
// Notes:   every level stands at least one machine cycle so the timer samples it
`timescale 1ns/1ns
`default_nettype none
module tmc_pin_src
  import tmc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_half,
  input  wire logic [1:0] i_gate,
  output logic      [1:0] o_pin,
  output logic      [1:0] o_gate
);
  logic [7:0] cnt;

  initial begin
    cnt    = 8'h00;
    o_pin  = 2'h3;
    o_gate = 2'h0;
  end

  // short levels could slip between two samples, so they are never made
  always @(posedge i_clk) begin
    o_gate <= i_gate;
    if (i_half < 8'h06) begin
      cnt   <= 8'h00;
      o_pin <= 2'h3;
    end else if (cnt == i_half - 8'h01) begin
      cnt   <= 8'h00;
      o_pin <= ~o_pin;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* test_tmc_timer.sv */
// Purpose: self-checking bench for the two timer/counters
// Assumes: one wait state per access, a machine cycle every six clocks
// Notes:   counts are compared as deltas over windows of whole machine cycles
`timescale 1ns/1ns
`default_nettype none
`include "tmc_cfg.svh"
module test_tmc_timer
  import tmc_pkg::*;
;
  logic        i_clk, i_reset, rd, wr, o0, o1, oe0, oe1, irq, baud, wreq;
  logic [7:0]  addr, half, a, b, x;
  logic [31:0] wdat, rdat;
  logic [3:0]  be;
  logic [1:0]  ack, gsel, gate, ppin;
  int          bad_count, n_tests, baud_n, n0, r, seed;

  tmc_timer tmc_timer_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_count_pin_zero(oe0 ? ppin[0] : o0), .i_count_pin_one(oe1 ? ppin[1] : o1),
    .o_count_pin_zero(o0), .o_count_pin_zero_oe_n(oe0), .o_count_pin_one(o1),
    .o_count_pin_one_oe_n(oe1), .i_ext_gate_input_zero(gate[0]),
    .i_ext_gate_input_one(gate[1]), .i_flag_ack(ack), .o_irq(irq), .o_baud_tick(baud));

  tmc_pin_src tmc_pin_src_inst (.i_clk(i_clk), .i_half(half), .i_gate(gsel),
    .o_pin(ppin), .o_gate(gate));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk) if (baud === 1'b1) baud_n <= baud_n + 1;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d,
                     output logic [7:0] q);
    int k;
    @(posedge i_clk);
    k = 0;
    addr <= ad;
    wdat <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge i_clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 20) begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic wr8(input logic [7:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d, x);
  endtask

  task automatic rd8(input logic [7:0] ad, output logic [7:0] q);
    bus(1'b0, ad, 8'h00, q);
  endtask

  // window counted from one read sample to the next
  task automatic delta(input logic [7:0] ad, input int w);
    rd8(ad, a);
    repeat (w - 3) @(posedge i_clk);
    rd8(ad, b);
  endtask

  function automatic logic [7:0] adv(input logic [1:0] m, input logic [7:0] v,
                                     input logic [7:0] hi, input int n);
    logic [7:0] q;
    q = v;
    for (int i = 0; i < n; i++) begin
      if (m == TMC_M13) q[4:0] = q[4:0] + 5'h01;
      else if (m == TMC_M8R) q = (q == 8'hFF) ? hi : q + 8'h01;
      else q = q + 8'h01;
    end
    return q;
  endfunction

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    seed = 66;
    {rd, wr, addr, wdat, be, ack, gsel, half} = '0;
    be = 4'hF;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd8(8'(i * 4), a);
      chk(a, 8'h00);
    end
    r = $random(seed);
    wr8(`TMC_OFF_MODE, r[7:0]);
    rd8(`TMC_OFF_MODE, a);
    chk(a, r[7:0]);
    r = $random(seed);
    wr8(`TMC_OFF_MODE, 8'h01);
    wr8(`TMC_OFF_LO0, r[7:0]);
    wr8(`TMC_OFF_CTRL, 8'h10);
    delta(`TMC_OFF_LO0, 60);
    chk(b, adv(TMC_M16, a, 8'h00, 10));
    wr8(`TMC_OFF_CTRL, 8'h00);
    wr8(`TMC_OFF_LO0, 8'h33);
    wr8(`TMC_OFF_MODE, 8'h09);
    wr8(`TMC_OFF_CTRL, 8'h10);
    rd8(`TMC_OFF_LO0, a);
    chk(a, 8'h33);
    gsel <= 2'b01;
    delta(`TMC_OFF_LO0, 60);
    chk(b, a + 8'h0A);
    wr8(`TMC_OFF_MODE, 8'h90);
    wr8(`TMC_OFF_CTRL, 8'h40);
    delta(`TMC_OFF_LO1, 60);
    chk(b, a);
    wr8(`TMC_OFF_CTRL, 8'h00);
    wr8(`TMC_OFF_MODE, 8'h01);
    wr8(`TMC_OFF_PORT, 8'h01);
    repeat (2) @(posedge i_clk);
    chk({6'h00, oe0, o0}, 8'h01);
    wr8(`TMC_OFF_IMASK, 8'h01);
    wr8(`TMC_OFF_HI0, 8'hFF);
    wr8(`TMC_OFF_LO0, 8'hFE);
    wr8(`TMC_OFF_CTRL, 8'h10);
    repeat (30) @(posedge i_clk);
    rd8(`TMC_OFF_CTRL, a);
    chk(a, 8'h30);
    chk({6'h00, irq, o0}, 8'h02);
    @(posedge i_clk) ack <= 2'b01;
    @(posedge i_clk) ack <= 2'b00;
    rd8(`TMC_OFF_CTRL, a);
    chk(a, 8'h10);
    rd8(`TMC_OFF_ISTAT, a);
    chk(a, 8'h01);
    wr8(`TMC_OFF_ISTAT, 8'h01);
    repeat (3) @(posedge i_clk);
    chk({7'h00, irq}, 8'h00);
    r = $random(seed);
    wr8(`TMC_OFF_CTRL, 8'h00);
    wr8(`TMC_OFF_MODE, 8'h20);
    wr8(`TMC_OFF_HI1, {4'hF, r[3:0]});
    // start near the top so the window holds an overflow
    wr8(`TMC_OFF_LO1, 8'hFA);
    wr8(`TMC_OFF_PORT, 8'h03);
    repeat (2) @(posedge i_clk);
    chk({6'h00, oe1, o1}, 8'h01);
    n0 = baud_n;
    wr8(`TMC_OFF_CTRL, 8'h40);
    delta(`TMC_OFF_LO1, 60);
    chk(b, adv(TMC_M8R, a, {4'hF, r[3:0]}, 10));
    rd8(`TMC_OFF_HI1, a);
    chk(a, {4'hF, r[3:0]});
    chk({7'h00, baud_n > n0}, 8'h01);
    rd8(`TMC_OFF_CTRL, a);
    chk({7'h00, a[7]}, 8'h01);
    wr8(`TMC_OFF_CTRL, 8'h00);
    wr8(`TMC_OFF_MODE, 8'h00);
    wr8(`TMC_OFF_LO0, 8'hFE);
    wr8(`TMC_OFF_CTRL, 8'h10);
    delta(`TMC_OFF_LO0, 60);
    chk(b, adv(TMC_M13, a, 8'h00, 10));
    wr8(`TMC_OFF_CTRL, 8'h00);
    wr8(`TMC_OFF_MODE, 8'h13);
    wr8(`TMC_OFF_HI0, 8'hFA);
    wr8(`TMC_OFF_CTRL, 8'h40);
    delta(`TMC_OFF_HI0, 60);
    chk(b, a + 8'h0A);
    rd8(`TMC_OFF_CTRL, a);
    chk({7'h00, a[7]}, 8'h01);
    delta(`TMC_OFF_LO0, 60);
    chk(b, a);
    delta(`TMC_OFF_LO1, 60);
    chk(b, a + 8'h0A);
    wr8(`TMC_OFF_MODE, 8'h33);
    delta(`TMC_OFF_LO1, 60);
    chk(b, a);
    wr8(`TMC_OFF_CTRL, 8'h00);
    wr8(`TMC_OFF_PORT, 8'h00);
    wr8(`TMC_OFF_MODE, 8'h05);
    half <= 8'h0C;
    wr8(`TMC_OFF_CTRL, 8'h10);
    delta(`TMC_OFF_LO0, 96);
    chk(b, a + 8'h04);
    stop_test();
  end
endmodule
`default_nettype wire
